// ---- logic/sideband_ctrl.sv ----
// Purpose: sideband control of a pluggable module (select, reset,
//          low power, presence, attention)
// Assumes: rst_n is the power-up / insertion reset; pins sampled on clk
// Notes: the two-wire bus engine sits outside; this block gates it
`timescale 1ns/1ps

// Notes on behaviour
// (RULE1) select low: module answers management bus commands to it
// (RULE2) select high: all management bus traffic is ignored; writes are gated, but flags_read still clears the fault and completion flags
// (RULE3) undriven select reads as high, so module stays silent
// (RULE4) reset low longer than minimum restores all settings to default
// (RULE5) reset execution starts when reset pin rises
// (RULE6) host ignores status bits until reset completion is signalled
// (RULE7) on completion, attention asserts with not-ready cleared
// (RULE8) after power-up, completion attention posted without reset pulse
// (RULE9) low-power input high selects reduced-power mode
// (RULE10) presence reads low while seated; host pull-up gives high
// (RULE11) attention pulled low on fault or critical status
// (RULE12) host reads cause over management bus after attention
// (RULE13) attention is open collector: drive low or release only
// (RULE14) module answers at its fixed lower page bus address
// (RULE15) host reads flag field to learn channel and flag type
// (RULE16) select, reset and low-power synchronised before use
module sideband_ctrl #(
  parameter int unsigned RESET_MIN = sideband_pkg::RESET_MIN_CYC,
  parameter int unsigned INIT_LEN = sideband_pkg::INIT_CYC
) (
  input wire logic clk, // 100 MHz management clock
  input wire logic rst_n, // power-up / insertion reset
  input wire logic bus_select_n_pin, // select pin, pulled high
  input wire logic bus_select_n_oe, // host drives select when high
  input wire logic module_reset_n, // host reset pin
  input wire logic low_power_request, // host low-power pin
  input wire logic bus_addr_valid, // bus engine decoded an address
  input wire logic [6:0] bus_addr, // decoded 7-bit bus address
  input wire logic fault_event, // one-cycle fault/critical event
  input wire logic flags_read, // host read the flag field (clears)
  input wire logic [7:0] ctrl_wdata, // control byte written by host
  input wire logic ctrl_we, // control byte write strobe
  output logic bus_enable, // bus engine may answer
  output logic addr_match, // address hit while selected
  output logic low_power_mode, // reduced-power mode active
  output logic data_not_ready, // not-ready status bit
  output logic fault_flag, // sticky fault flag
  output logic [7:0] ctrl_q, // user control settings
  output logic presence_n, // presence pin, low while seated
  output logic attention_n_o, // attention pin output value
  output logic attention_n_oe // attention pin driven low when high
);

  //--------------------------------------------------------------
  // input synchronisation
  //--------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HELD = 2'b01,
    ST_INIT = 2'b10
  } rst_state_e;

  sync_if #(.W(sideband_pkg::SYNC_W)) sif ();
  logic sel_raw;

  // pull-up: an undriven select pin reads as deselected
  assign sel_raw = bus_select_n_oe ? bus_select_n_pin : 1'b1; // RULE3
  assign sif.raw = {low_power_request, module_reset_n, sel_raw};

  level_sync #(
    .W(sideband_pkg::SYNC_W),
    .RST_VAL(sideband_pkg::SYNC_RESET_VAL)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .s(sif.snk)
  ); // RULE16

  wire sel_n_s = sif.synced[sideband_pkg::SYNC_SEL];
  wire rst_pin_s = sif.synced[sideband_pkg::SYNC_RST];
  wire lp_s = sif.synced[sideband_pkg::SYNC_LP];

  //--------------------------------------------------------------
  // reset pin sequencing
  //--------------------------------------------------------------
  rst_state_e state_q, state_d;
  logic [sideband_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic rst_pin_q;
  logic done_pulse;
  logic long_low;
  logic rise;

  assign rise = rst_pin_s & ~rst_pin_q;
  assign long_low = (cnt_q >= sideband_pkg::CNT_W'(RESET_MIN));
  assign done_pulse = (state_q == ST_INIT) &&
    (cnt_q == sideband_pkg::CNT_W'(INIT_LEN - 1));

  // held counts low time; a short glitch returns to run untouched
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_RUN: begin
        if (!rst_pin_s) begin
          state_d = ST_HELD;
          cnt_d = '0;
        end
      end
      ST_HELD: begin
        if (rise && long_low) begin
          state_d = ST_INIT; // RULE5
          cnt_d = '0;
        end else if (rst_pin_s) begin
          state_d = ST_RUN;
        end else if (!long_low) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_INIT: begin
        if (!rst_pin_s) begin
          state_d = ST_HELD;
          cnt_d = '0;
        end else if (done_pulse) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // power-up enters the init interval directly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_INIT; // RULE8
      cnt_q <= '0;
      rst_pin_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rst_pin_q <= rst_pin_s;
    end
  end

  wire full_reset = (state_q == ST_HELD) && long_low;
  wire in_reset = (state_q != ST_RUN);

  //--------------------------------------------------------------
  // settings, status and attention
  //--------------------------------------------------------------
  wire hit = bus_addr_valid && (bus_addr == sideband_pkg::DEV_ADDR);

  // settings return to default on a full reset
  always_ff @(posedge clk) begin
    if (!rst_n || full_reset) begin
      ctrl_q <= sideband_pkg::CTRL_DEFAULT; // RULE4
    end else if (ctrl_we && bus_enable) begin
      ctrl_q <= ctrl_wdata;
    end
  end

  // status: set wins over a read-clear; faults are dropped while the reset pin is held low and during reset execution
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_not_ready <= 1'b1;
      fault_flag <= 1'b0;
    end else begin
      data_not_ready <= in_reset && !done_pulse; // RULE7
      if (fault_event && !in_reset) begin
        fault_flag <= 1'b1; // RULE11
      end else if (flags_read || done_pulse) begin
        fault_flag <= 1'b0;
      end
    end
  end

  // completion posts a sticky attention cleared by a flag read
  logic done_att_q;
  always_ff @(posedge clk) begin
    if (!rst_n || full_reset) begin
      done_att_q <= 1'b0;
    end else if (done_pulse) begin
      done_att_q <= 1'b1; // RULE7
    end else if (flags_read) begin
      done_att_q <= 1'b0;
    end
  end

  wire att_next = done_att_q || fault_flag || (done_pulse && 1'b1);

  // bus gating and pins, all registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_enable <= 1'b0;
      addr_match <= 1'b0;
      low_power_mode <= 1'b0;
      presence_n <= 1'b0;
      attention_n_o <= 1'b0;
      attention_n_oe <= 1'b0;
    end else begin
      bus_enable <= !sel_n_s; // RULE1 RULE2
      addr_match <= !sel_n_s && hit; // RULE14
      low_power_mode <= lp_s; // RULE9
      presence_n <= 1'b0; // RULE10
      attention_n_o <= 1'b0; // RULE13
      attention_n_oe <= att_next; // RULE13
    end
  end

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  // power-up watchdog: counts the init interval up to the first
  // completion; a counter keeps the check cheap for long intervals
  logic pu_wait_q;
  logic [sideband_pkg::CNT_W-1:0] pu_cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pu_wait_q <= 1'b1;
      pu_cnt_q <= '0;
    end else if (done_pulse || state_q != ST_INIT) begin
      pu_wait_q <= 1'b0;
    end else if (pu_wait_q) begin
      pu_cnt_q <= pu_cnt_q + 1'b1;
    end
  end

  a_sel_gates_bus: assert property ( // RULE2
    @(posedge clk) disable iff (!rst_n)
    sel_n_s |=> !bus_enable)
    else $error("bus enabled while deselected");
  a_sel_opens_bus: assert property ( // RULE1
    @(posedge clk) disable iff (!rst_n)
    !sel_n_s |=> bus_enable)
    else $error("bus not enabled while selected");
  a_float_silent: assert property ( // RULE3
    @(posedge clk) disable iff (!rst_n)
    (!bus_select_n_oe)[*3] |=> !bus_enable)
    else $error("undriven select opened bus");
  a_reset_defaults: assert property ( // RULE4
    @(posedge clk) disable iff (!rst_n)
    full_reset |=> ctrl_q == sideband_pkg::CTRL_DEFAULT)
    else $error("settings not defaulted");
  a_short_ignored: assert property ( // RULE4
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_HELD && rst_pin_s && !long_low) |=> state_q == ST_RUN)
    else $error("short reset pulse not ignored");
  a_init_on_rise: assert property ( // RULE5
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_HELD && rise && long_low) |=> state_q == ST_INIT)
    else $error("init not started on rise");
  a_notready_init: assert property ( // RULE7
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_INIT && !done_pulse) |=> data_not_ready)
    else $error("not-ready dropped before completion");
  a_done_attention: assert property ( // RULE7
    @(posedge clk) disable iff (!rst_n)
    done_pulse |=> attention_n_oe && !data_not_ready)
    else $error("completion not signalled");
  a_powerup_done: assert property ( // RULE8
    @(posedge clk) disable iff (!rst_n)
    pu_wait_q |-> pu_cnt_q < sideband_pkg::CNT_W'(INIT_LEN))
    else $error("no completion after power-up");
  a_lp_follows: assert property ( // RULE9
    @(posedge clk) disable iff (!rst_n)
    lp_s |=> low_power_mode)
    else $error("low power not applied");
  a_present_low: assert property ( // RULE10
    @(posedge clk) disable iff (!rst_n)
    !presence_n)
    else $error("presence not low");
  a_fault_att: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_n)
    fault_flag |=> attention_n_oe)
    else $error("fault without attention");
  a_sticky_fault: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_n)
    (fault_flag && !flags_read && !done_pulse) |=> fault_flag)
    else $error("fault flag lost before read");
  a_init_no_fault: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_n)
    (in_reset && fault_event && !fault_flag) |=> !fault_flag)
    else $error("fault taken during reset execution");
  a_flag_clear: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_n)
    (flags_read && !fault_event) |=> !fault_flag)
    else $error("flag read did not clear fault");
  a_open_coll: assert property ( // RULE13
    @(posedge clk) disable iff (!rst_n)
    !attention_n_o)
    else $error("attention driven high");
  a_addr_gated: assert property ( // RULE14
    @(posedge clk) disable iff (!rst_n)
    addr_match |-> bus_enable)
    else $error("address hit while deselected");
  a_ctrl_hold: assert property ( // RULE2
    @(posedge clk) disable iff (!rst_n)
    (!ctrl_we || !bus_enable) && !full_reset |=> $stable(ctrl_q))
    else $error("settings changed without a write");
  a_write_lands: assert property ( // RULE1
    @(posedge clk) disable iff (!rst_n)
    (ctrl_we && bus_enable && !full_reset) |=> ctrl_q == $past(ctrl_wdata))
    else $error("selected write did not land");

  c_full_reset: cover property (@(posedge clk) disable iff (!rst_n)
    full_reset ##[1:300] done_pulse);
  c_fault: cover property (@(posedge clk) disable iff (!rst_n)
    fault_flag ##1 flags_read);
  c_select: cover property (@(posedge clk) disable iff (!rst_n)
    addr_match);
  c_powerup: cover property (@(posedge clk) disable iff (!rst_n)
    pu_wait_q && done_pulse);
  c_short_pulse: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_HELD && rst_pin_s && !long_low);
endmodule : sideband_ctrl

// ---- logic/sideband_pkg.sv ----
// Purpose: constants for the module sideband control logic
// Assumes: 100 MHz management clock
// Notes: times are in ns, cycle counts derived from them
package sideband_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // least low time on the reset pin that counts as a reset
  localparam int unsigned RESET_MIN_NS = 10000;
  localparam int unsigned RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // reset execution interval after release
  localparam int unsigned INIT_NS = 20000;
  localparam int unsigned INIT_CYC =
    (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 12;
  // management bus address of the lower page
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam int unsigned SYNC_W = 3;
  // synchroniser bit positions
  localparam int unsigned SYNC_SEL = 0;
  localparam int unsigned SYNC_RST = 1;
  localparam int unsigned SYNC_LP = 2;
  localparam logic [2:0] SYNC_RESET_VAL = 3'h3;
  localparam logic [7:0] CTRL_DEFAULT = 8'h00;
endpackage : sideband_pkg

// ---- logic/sync_if.sv ----
// Purpose: carries raw and synchronised sideband levels
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface sync_if #(parameter int W = 3);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface : sync_if

// ---- logic/level_sync.sv ----
// Purpose: two-flop synchroniser for host sideband levels
// Assumes: inputs change asynchronously to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 3,
  parameter logic [2:0] RST_VAL = 3'h3
) (
  input wire logic clk, // management clock
  input wire logic rst_n, // synchronous reset
  sync_if.snk s // raw in, synced out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stab_q;

  // two stages; reset to the idle (deasserted) pin levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL[W-1:0];
      stab_q <= RST_VAL[W-1:0];
    end else begin
      meta_q <= s.raw;
      stab_q <= meta_q;
    end
  end
  assign s.synced = stab_q;
endmodule : level_sync

// ---- verification/host_port_model.sv ----
// Purpose: host port controller model driving the sideband pins
// Assumes: pins change just after a rising clock edge
// Notes: host pull-ups resolve the open-collector attention wire
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk, // management clock
  input wire logic attention_n_oe, // module pulls attention low
  input wire logic presence_n, // presence from the module
  output logic sel_pin, // select pin level
  output logic sel_oe, // host drives select when high
  output logic reset_pin_n, // module reset pin
  output logic lp_pin, // low-power pin
  output logic attention_line, // resolved attention wire
  output logic presence_line // resolved presence wire
);
  // ------------------------------------------------------------
  // wires and pins
  // ------------------------------------------------------------
  // released attention reads high through the host pull-up
  assign attention_line = attention_n_oe ? 1'h0 : 1'h1;
  assign presence_line = presence_n;
  // pins idle deselected and out of reset
  initial begin
    sel_pin = 1'h1;
    sel_oe = 1'h1;
    reset_pin_n = 1'h1;
    lp_pin = 1'h0;
  end
  // one edge per call keeps every pin change clear of sampling
  task set_pins(input logic oe, input logic sel, input logic rst,
                input logic lp);
    @(posedge clk);
    sel_oe <= oe;
    sel_pin <= sel;
    reset_pin_n <= rst;
    lp_pin <= lp;
  endtask : set_pins
endmodule : host_port_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the sideband control block
// Assumes: short reset and init counts of 4 and 8 cycles
// Notes: status is read during reset execution and after the completion attention
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic addr_valid = 1'h0;
  logic fault_event = 1'h0;
  logic flags_read = 1'h0;
  logic ctrl_we = 1'h0;
  logic [6:0] bus_addr = 7'h00;
  logic [7:0] ctrl_wdata = 8'h00;
  logic sel_pin, sel_oe, reset_pin_n, lp_pin, attention_line;
  logic presence_line, bus_enable, addr_match, low_power_mode;
  logic data_not_ready, fault_flag, presence_n, attention_n_oe;
  logic attention_n_o;
  logic [7:0] ctrl_q;
  logic [4:0] obs;
  int n_fail = 0;
  int n_compared = 0;
  assign obs = {addr_match, low_power_mode, attention_line,
                data_not_ready, bus_enable};
  always #5 clk = ~clk;
  sideband_ctrl #(.RESET_MIN(4), .INIT_LEN(8)) dut (
    .clk(clk), .rst_n(rst_n), .bus_select_n_pin(sel_pin),
    .bus_select_n_oe(sel_oe), .module_reset_n(reset_pin_n),
    .low_power_request(lp_pin), .bus_addr_valid(addr_valid),
    .bus_addr(bus_addr), .fault_event(fault_event),
    .flags_read(flags_read), .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we),
    .bus_enable(bus_enable), .addr_match(addr_match),
    .low_power_mode(low_power_mode), .data_not_ready(data_not_ready),
    .fault_flag(fault_flag), .ctrl_q(ctrl_q), .presence_n(presence_n),
    .attention_n_o(attention_n_o), .attention_n_oe(attention_n_oe));
  host_port_model host (
    .clk(clk), .attention_n_oe(attention_n_oe), .presence_n(presence_n),
    .sel_pin(sel_pin), .sel_oe(sel_oe), .reset_pin_n(reset_pin_n),
    .lp_pin(lp_pin), .attention_line(attention_line),
    .presence_line(presence_line));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // bounded wait on one observed bit; a timeout ends the run
  task wait_for(input int idx, input logic val);
    int k;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (obs[idx] !== val && k < 60);
    check({7'h00, obs[idx]}, {7'h00, val});
    if (obs[idx] !== val) complete_run();
  endtask : wait_for
  // one-cycle strobe: 0 address, 1 fault, 2 flag read, 3 write
  task pulse(input int which, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= d[6:0];
    ctrl_wdata <= d;
    addr_valid <= (which == 0);
    fault_event <= (which == 1);
    flags_read <= (which == 2);
    ctrl_we <= (which == 3);
    @(posedge clk);
    {addr_valid, fault_event, flags_read, ctrl_we} <= 4'h0;
    #1;
  endtask : pulse
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(3);
    check({bus_enable, data_not_ready, attention_n_oe}, 8'h02);
    check(ctrl_q, 8'h00);
    @(posedge clk);
    rst_n <= 1'h1;
    wait_for(2, 1'h0);
    check(data_not_ready, 8'h00);
    check(presence_line, 8'h00);
    pulse(2, 8'h00);
    wait_for(2, 1'h1);
    host.set_pins(1'h1, 1'h0, 1'h1, 1'h0);
    wait_for(0, 1'h1);
    pulse(0, 8'h50);
    check(addr_match, 8'h01);
    pulse(0, 8'h51);
    check(addr_match, 8'h00);
    pulse(3, 8'hA5);
    cyc(1);
    check(ctrl_q, 8'hA5);
    host.set_pins(1'h1, 1'h0, 1'h1, 1'h1);
    wait_for(3, 1'h1);
    host.set_pins(1'h1, 1'h1, 1'h1, 1'h1);
    cyc(4);
    check(bus_enable, 8'h00);
    pulse(0, 8'h50);
    check(addr_match, 8'h00);
    pulse(3, 8'h5A);
    cyc(1);
    check(ctrl_q, 8'hA5);
    host.set_pins(1'h0, 1'h0, 1'h1, 1'h1);
    cyc(4);
    check(bus_enable, 8'h00);
    host.set_pins(1'h1, 1'h0, 1'h0, 1'h1);
    host.set_pins(1'h1, 1'h0, 1'h1, 1'h1);
    cyc(8);
    check(ctrl_q, 8'hA5);
    host.set_pins(1'h1, 1'h0, 1'h0, 1'h1);
    cyc(10);
    check(ctrl_q, 8'h00);
    host.set_pins(1'h1, 1'h0, 1'h1, 1'h1);
    cyc(6);
    check({data_not_ready, attention_line}, 8'h03);
    pulse(1, 8'h00);
    check(fault_flag, 8'h00);
    wait_for(2, 1'h0);
    check(data_not_ready, 8'h00);
    pulse(2, 8'h00);
    wait_for(2, 1'h1);
    pulse(1, 8'h00);
    wait_for(2, 1'h0);
    check(fault_flag, 8'h01);
    pulse(2, 8'h00);
    wait_for(2, 1'h1);
    check(fault_flag, 8'h00);
    check(attention_n_o, 8'h00);
    complete_run();
  end
endmodule : tb_top
